/* design/fxfer_pkg.sv */
// Purpose: shared constants for the far transfer privilege check block
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes: privilege level 0 is the most privileged, 3 the least
package fxfer_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W = 16;
  localparam int OFF_W = 32;
  localparam int PL_W = 2;
  localparam logic [1:0] PL_MOST = 2'h0;
  localparam logic [1:0] PL_LEAST = 2'h3;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TSEL = 8'h04;
  localparam logic [7:0] OFF_TOFF = 8'h08;
  localparam logic [7:0] OFF_TDESC = 8'h0C;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_CODE_SEG = 8'h14;
  localparam logic [7:0] OFF_IPTR = 8'h18;
  localparam logic [7:0] OFF_CAUSE = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;

  // field positions
  localparam int CTRL_LONG_BIT = 0;
  localparam int CTRL_LEVEL_LSB = 4;
  localparam int DESC_LEVEL_LSB = 0;
  localparam int DESC_CONF_BIT = 2;
  localparam int SEL_REQ_LSB = 0;
  localparam int CMD_KIND_W = 3;

  // transfer kinds written to the command register
  localparam logic [2:0] KIND_NEAR = 3'h0;
  localparam logic [2:0] KIND_FAR_DIRECT = 3'h1;
  localparam logic [2:0] KIND_FAST_ENTRY = 3'h2;
  localparam logic [2:0] KIND_FAST_EXIT = 3'h3;
  localparam logic [2:0] KIND_TASK_SWITCH = 3'h4;

  // fault cause codes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_LEVEL_NE = 3'h1;
  localparam logic [2:0] CAUSE_REQ_GT = 3'h2;
  localparam logic [2:0] CAUSE_DESC_GT = 3'h3;
  localparam logic [2:0] CAUSE_UNSUPPORTED = 3'h4;

  // event bits of status and mask registers
  localparam int EV_GRANT = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_UNSUP = 2;
  localparam int EV_W = 3;

  // reset values
  localparam logic [15:0] CODE_SEG_RST = 16'h0000;
  localparam logic [31:0] IPTR_RST = 32'h0000_0000;
  localparam logic [1:0] LEVEL_RST = 2'h0;

  // selector as it enters the code-segment register: requested field replaced by current level
  function automatic logic [15:0] load_selector(input logic [15:0] sel, input logic [1:0] level);
    load_selector = {sel[15:2], level};
  endfunction : load_selector

endpackage : fxfer_pkg

/* design/priv_compare.sv */
// Purpose: combinational privilege comparison for a direct far transfer
// Assumes: inputs come from registers of the same clock
// Notes: conforming and nonconforming paths chosen by the descriptor flag
`timescale 1ns/10ps
module priv_compare (
  input wire logic [1:0] current_priv_level,
  input wire logic [1:0] requested_priv_level,
  input wire logic [1:0] descriptor_priv_level,
  input wire logic conforming,
  output logic pass,
  output logic [2:0] cause
);

  always_comb
  begin
    pass = 1'b0;
    cause = fxfer_pkg::CAUSE_NONE;
    if (conforming)
    begin
      // descriptor level at most current; requested level unused
      if (descriptor_priv_level <= current_priv_level)
        pass = 1'b1;
      else
        cause = fxfer_pkg::CAUSE_DESC_GT;
    end
    else if (descriptor_priv_level != current_priv_level)
      cause = fxfer_pkg::CAUSE_LEVEL_NE;
    else if (requested_priv_level <= current_priv_level)
      pass = 1'b1;
    else
      cause = fxfer_pkg::CAUSE_REQ_GT;
  end

endmodule : priv_compare

/* design/event_irq.sv */
// Purpose: sticky event status, mask and level interrupt
// Assumes: one-cycle event pulses, write-one-to-clear status
// Notes: a set in the clearing cycle wins over the clear
`timescale 1ns/10ps
module event_irq (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [2:0] event_set,
  input wire logic stat_clr_wr,
  input wire logic mask_wr,
  input wire logic [2:0] wr_bits,
  output logic [2:0] stat_q,
  output logic [2:0] mask_q,
  output logic irq_q
);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      stat_q <= 3'h0;
    else
      stat_q <= (stat_q & ~(stat_clr_wr ? wr_bits : 3'h0)) | event_set;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      mask_q <= 3'h0;
    else if (mask_wr)
      mask_q <= wr_bits;
  end

  // follows the masked status one cycle later
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_q & mask_q);
  end

  property p_irq_level;
    @(posedge ref_clk) disable iff (!rst_b)
    1'b1 |=> (irq_q == $past(|(stat_q & mask_q)));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level does not follow masked status");

endmodule : event_irq

/* design/far_transfer_privilege_check.sv */
// Purpose: privilege check and register update for far control transfers
// Assumes: register port with one-cycle strobes, read data one cycle later
// Notes: a transfer is requested by writing its kind to the command register
//
// Overview of operation
// - every inter-segment transfer is checked before target entry is decided
// - granted far transfer loads target selector into code-segment register
// - granted transfer sets instruction pointer to the target offset
// - near transfers skip privilege checks entirely
// - fast system entry and exit are unsupported in long mode
// - hardware task switches by call or jump unsupported in long mode
// - direct far call or jump never changes the current level
// - direct far transfers never switch stacks
// - descriptor conforming flag selects which check rules apply
// - nonconforming: descriptor level must equal current level, else fault
// - nonconforming: requested level must not exceed current level, else fault
// - nonconforming grant keeps level; selector requested field ignored on load
// - conforming: descriptor level must not exceed current level, else fault
// - conforming: requested level plays no part in the decision
// - conforming grant runs at caller level; selector field takes old level
// - privilege levels span zero, most privileged, to three, least
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
module far_transfer_privilege_check (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data_q,
  output logic [15:0] code_seg_q,
  output logic [31:0] instruction_pointer_q,
  output logic [1:0] current_priv_level_q,
  output logic general_protection_fault_q,
  output logic unsupported_q,
  output logic transfer_done_q,
  output logic irq_q
);

  logic long_mode_q;
  logic [15:0] tsel_q;
  logic [31:0] toff_q;
  logic [1:0] tdpl_q;
  logic tconf_q;
  logic [2:0] cause_q;
  logic [2:0] stat_q;
  logic [2:0] mask_q;

  logic cmd_go;
  logic [2:0] cmd_kind;
  logic chk_pass;
  logic [2:0] chk_cause;
  logic grant_d;
  logic fault_d;
  logic unsup_d;
  logic near_d;
  logic [2:0] cause_d;
  logic [2:0] event_set;
  logic [31:0] rd_data_d;

  assign cmd_go = wr_en && (addr == fxfer_pkg::OFF_CMD);
  assign cmd_kind = wr_data[fxfer_pkg::CMD_KIND_W-1:0];

  priv_compare u_cmp (
    .current_priv_level(current_priv_level_q),
    .requested_priv_level(tsel_q[fxfer_pkg::SEL_REQ_LSB +: fxfer_pkg::PL_W]),
    .descriptor_priv_level(tdpl_q),
    .conforming(tconf_q),
    .pass(chk_pass),
    .cause(chk_cause)
  );

  // software-visible target and mode registers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      long_mode_q <= 1'b0;
      tsel_q <= 16'h0000;
      toff_q <= 32'h0000_0000;
      tdpl_q <= 2'h0;
      tconf_q <= 1'b0;
    end
    else if (wr_en)
    begin
      unique case (addr)
        fxfer_pkg::OFF_CTRL: long_mode_q <= wr_data[fxfer_pkg::CTRL_LONG_BIT];
        fxfer_pkg::OFF_TSEL: tsel_q <= wr_data[15:0];
        fxfer_pkg::OFF_TOFF: toff_q <= wr_data;
        fxfer_pkg::OFF_TDESC:
        begin
          tdpl_q <= wr_data[fxfer_pkg::DESC_LEVEL_LSB +: fxfer_pkg::PL_W];
          tconf_q <= wr_data[fxfer_pkg::DESC_CONF_BIT];
        end
        default: ;
      endcase
    end
  end

  // decision for the transfer requested this cycle
  always_comb
  begin
    grant_d = 1'b0;
    fault_d = 1'b0;
    unsup_d = 1'b0;
    near_d = 1'b0;
    cause_d = fxfer_pkg::CAUSE_NONE;
    if (cmd_go)
    begin
      case (cmd_kind)
        fxfer_pkg::KIND_NEAR: near_d = 1'b1;
        // far transfer decided by the comparator
        fxfer_pkg::KIND_FAR_DIRECT:
        begin
          grant_d = chk_pass;
          fault_d = !chk_pass;
          cause_d = chk_cause;
        end
        // no fast entry or exit in long mode
        fxfer_pkg::KIND_FAST_ENTRY,
        fxfer_pkg::KIND_FAST_EXIT:
        begin
          unsup_d = long_mode_q;
          cause_d = long_mode_q ? fxfer_pkg::CAUSE_UNSUPPORTED : fxfer_pkg::CAUSE_NONE;
        end
        // no task switch in long mode
        fxfer_pkg::KIND_TASK_SWITCH:
        begin
          unsup_d = long_mode_q;
          cause_d = long_mode_q ? fxfer_pkg::CAUSE_UNSUPPORTED : fxfer_pkg::CAUSE_NONE;
        end
        // unknown kinds are refused the same way
        default:
        begin
          unsup_d = 1'b1;
          cause_d = fxfer_pkg::CAUSE_UNSUPPORTED;
        end
      endcase
    end
  end

  // code-segment register
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      code_seg_q <= fxfer_pkg::CODE_SEG_RST;
    // load on grant; requested field becomes old level
    else if (grant_d)
      code_seg_q <= fxfer_pkg::load_selector(tsel_q, current_priv_level_q);
  end

  // instruction pointer; a fault leaves it alone
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      instruction_pointer_q <= fxfer_pkg::IPTR_RST;
    // target offset from the far pointer
    else if (grant_d || near_d)
      instruction_pointer_q <= toff_q;
  end

  // only software sets the level; transfers never touch it
  // no stack state exists on the direct path, nothing is swapped
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      current_priv_level_q <= fxfer_pkg::LEVEL_RST;
    else if (wr_en && (addr == fxfer_pkg::OFF_CTRL))
      current_priv_level_q <= wr_data[fxfer_pkg::CTRL_LEVEL_LSB +: fxfer_pkg::PL_W];
  end

  // fault, unsupported and done pulses, one cycle after the command
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      general_protection_fault_q <= 1'b0;
      unsupported_q <= 1'b0;
      transfer_done_q <= 1'b0;
    end
    else
    begin
      general_protection_fault_q <= fault_d;
      unsupported_q <= unsup_d;
      transfer_done_q <= cmd_go;
    end
  end

  // cause of the latest command, kept until the next one
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      cause_q <= fxfer_pkg::CAUSE_NONE;
    else if (cmd_go)
      cause_q <= cause_d;
  end

  always_comb
  begin
    event_set = 3'h0;
    event_set[fxfer_pkg::EV_GRANT] = grant_d;
    event_set[fxfer_pkg::EV_FAULT] = fault_d;
    event_set[fxfer_pkg::EV_UNSUP] = unsup_d;
  end

  event_irq u_irq (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .event_set(event_set),
    .stat_clr_wr(wr_en && (addr == fxfer_pkg::OFF_IRQ_STAT)),
    .mask_wr(wr_en && (addr == fxfer_pkg::OFF_IRQ_MASK)),
    .wr_bits(wr_data[fxfer_pkg::EV_W-1:0]),
    .stat_q(stat_q),
    .mask_q(mask_q),
    .irq_q(irq_q)
  );

  // read mux; unmapped and write-only offsets read zero
  always_comb
  begin
    rd_data_d = 32'h0000_0000;
    unique case (addr)
      fxfer_pkg::OFF_CTRL:
      begin
        rd_data_d[fxfer_pkg::CTRL_LONG_BIT] = long_mode_q;
        rd_data_d[fxfer_pkg::CTRL_LEVEL_LSB +: fxfer_pkg::PL_W] = current_priv_level_q;
      end
      fxfer_pkg::OFF_TSEL: rd_data_d[15:0] = tsel_q;
      fxfer_pkg::OFF_TOFF: rd_data_d = toff_q;
      fxfer_pkg::OFF_TDESC:
      begin
        rd_data_d[fxfer_pkg::DESC_LEVEL_LSB +: fxfer_pkg::PL_W] = tdpl_q;
        rd_data_d[fxfer_pkg::DESC_CONF_BIT] = tconf_q;
      end
      fxfer_pkg::OFF_CODE_SEG: rd_data_d[15:0] = code_seg_q;
      fxfer_pkg::OFF_IPTR: rd_data_d = instruction_pointer_q;
      fxfer_pkg::OFF_CAUSE: rd_data_d[2:0] = cause_q;
      fxfer_pkg::OFF_IRQ_STAT: rd_data_d[2:0] = stat_q;
      fxfer_pkg::OFF_IRQ_MASK: rd_data_d[2:0] = mask_q;
      default: ;
    endcase
  end

  // data valid only in the cycle after the read strobe
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data_q <= 32'h0000_0000;
    else if (rd_en)
      rd_data_q <= rd_data_d;
    else
      rd_data_q <= 32'h0000_0000;
  end

  sequence s_far_cmd;
    cmd_go && (cmd_kind == fxfer_pkg::KIND_FAR_DIRECT);
  endsequence

  sequence s_state_kept;
    $stable(code_seg_q) && $stable(instruction_pointer_q) && $stable(current_priv_level_q);
  endsequence

  property p_near_unchecked;
    @(posedge ref_clk) disable iff (!rst_b)
    (cmd_go && (cmd_kind == fxfer_pkg::KIND_NEAR)) |=>
      !general_protection_fault_q && $stable(code_seg_q) && (instruction_pointer_q == $past(toff_q));
  endproperty
  a_near_unchecked: assert property (p_near_unchecked)
    else $error("near transfer was checked or mis-updated");

  property p_nc_level_ne;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_far_cmd and (!tconf_q && (tdpl_q != current_priv_level_q))) |=>
      general_protection_fault_q && (cause_q == fxfer_pkg::CAUSE_LEVEL_NE);
  endproperty
  a_nc_level_ne: assert property (p_nc_level_ne)
    else $error("nonconforming level mismatch not faulted");

  property p_nc_req_gt;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_far_cmd and (!tconf_q && (tdpl_q == current_priv_level_q) && (tsel_q[1:0] > current_priv_level_q)))
      |=> general_protection_fault_q && (cause_q == fxfer_pkg::CAUSE_REQ_GT);
  endproperty
  a_nc_req_gt: assert property (p_nc_req_gt)
    else $error("requested level above current not faulted");

  property p_conf_desc_gt;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_far_cmd and (tconf_q && (tdpl_q > current_priv_level_q))) |=>
      general_protection_fault_q && (cause_q == fxfer_pkg::CAUSE_DESC_GT);
  endproperty
  a_conf_desc_gt: assert property (p_conf_desc_gt)
    else $error("conforming target of lower privilege not faulted");

  property p_conf_req_ignored;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_far_cmd and (tconf_q && (tdpl_q <= current_priv_level_q))) |=>
      !general_protection_fault_q && (stat_q[fxfer_pkg::EV_GRANT]);
  endproperty
  a_conf_req_ignored: assert property (p_conf_req_ignored)
    else $error("conforming grant depended on requested level");

  property p_cs_loaded;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_far_cmd and chk_pass) |=>
      (code_seg_q == {$past(tsel_q[15:2]), $past(current_priv_level_q)})
      && (instruction_pointer_q == $past(toff_q));
  endproperty
  a_cs_loaded: assert property (p_cs_loaded)
    else $error("granted transfer did not load selector and offset");

  property p_cpl_kept;
    @(posedge ref_clk) disable iff (!rst_b)
    s_far_cmd |=> $stable(current_priv_level_q) ##1 $stable(current_priv_level_q) || $past(wr_en);
  endproperty
  a_cpl_kept: assert property (p_cpl_kept)
    else $error("far transfer changed the current level");

  property p_fault_holds;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_far_cmd and !chk_pass) |=> s_state_kept;
  endproperty
  a_fault_holds: assert property (p_fault_holds)
    else $error("faulted transfer modified architectural state");

  property p_long_unsup;
    @(posedge ref_clk) disable iff (!rst_b)
    (cmd_go && long_mode_q && ((cmd_kind == fxfer_pkg::KIND_FAST_ENTRY)
      || (cmd_kind == fxfer_pkg::KIND_FAST_EXIT) || (cmd_kind == fxfer_pkg::KIND_TASK_SWITCH)))
      |=> (unsupported_q && (cause_q == fxfer_pkg::CAUSE_UNSUPPORTED)) and s_state_kept;
  endproperty
  a_long_unsup: assert property (p_long_unsup)
    else $error("long-mode entry or task switch was not refused");

  property p_done_once;
    @(posedge ref_clk) disable iff (!rst_b)
    cmd_go |=> transfer_done_q ##1 (!transfer_done_q || $past(cmd_go));
  endproperty
  a_done_once: assert property (p_done_once)
    else $error("completion pulse missing or stretched");

endmodule : far_transfer_privilege_check

/* sim/far_transfer_privilege_check_test.sv */
// Purpose: self-checking bench for the far transfer privilege check block
// Assumes: register port with one-cycle strobes, read data one cycle after
// Notes: expected values are worked out from the check rules, never read back
`timescale 1ns/10ps
module far_transfer_privilege_check_test;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data_q;
  logic [15:0] code_seg_q;
  logic [31:0] instruction_pointer_q;
  logic [1:0] current_priv_level_q;
  logic general_protection_fault_q;
  logic unsupported_q;
  logic transfer_done_q;
  logic irq_q;
  int miscompares = 0;
  int n_checks = 0;
  logic [1:0] cur = 2'h0;
  logic [15:0] exp_cs = 16'h0000;
  logic [31:0] exp_ip = 32'h0000_0000;
  logic [15:0] sel;
  logic [31:0] toff;
  logic [2:0] ec;
  logic ok;

  far_transfer_privilege_check i_far_transfer_privilege_check (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .addr(addr),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .rd_data_q(rd_data_q),
    .code_seg_q(code_seg_q),
    .instruction_pointer_q(instruction_pointer_q),
    .current_priv_level_q(current_priv_level_q),
    .general_protection_fault_q(general_protection_fault_q),
    .unsupported_q(unsupported_q),
    .transfer_done_q(transfer_done_q),
    .irq_q(irq_q)
  );

  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    chk(n, e, rd_data_q);
  endtask : rdchk

  // pulses stand one cycle, state compared against tracked expectations
  task automatic cmd(input logic [2:0] k, input logic f, input logic u);
    wr(fxfer_pkg::OFF_CMD, {29'h0, k});
    chk("fault", {31'h0, f}, {31'h0, general_protection_fault_q});
    chk("unsup", {31'h0, u}, {31'h0, unsupported_q});
    chk("done", 32'h0000_0001, {31'h0, transfer_done_q});
    chk("code_seg", {16'h0, exp_cs}, {16'h0, code_seg_q});
    chk("iptr", exp_ip, instruction_pointer_q);
    chk("level", {30'h0, cur}, {30'h0, current_priv_level_q});
    @(posedge ref_clk);
    #1;
    chk("pulses", 32'h0, {29'h0, general_protection_fault_q, unsupported_q, transfer_done_q});
  endtask : cmd

  task automatic end_test(input string n);
    $display("test %s done", n);
  endtask : end_test

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    $display("mismatch watchdog expected 0 seen 1");
    miscompares++;
    final_report();
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk("level rst", 32'h0, {30'h0, current_priv_level_q});
    rdchk("ctrl rst", fxfer_pkg::OFF_CTRL, 32'h0);
    rdchk("cs rst", fxfer_pkg::OFF_CODE_SEG, 32'h0);
    rdchk("ip rst", fxfer_pkg::OFF_IPTR, 32'h0);
    rdchk("stat rst", fxfer_pkg::OFF_IRQ_STAT, 32'h0);
    rdchk("mask rst", fxfer_pkg::OFF_IRQ_MASK, 32'h0);
    end_test("reset");
    // unused bits read zero, write-only and unmapped places read zero
    wr(fxfer_pkg::OFF_CTRL, 32'hFFFF_FFFF);
    rdchk("ctrl", fxfer_pkg::OFF_CTRL, 32'h0000_0031);
    wr(fxfer_pkg::OFF_TSEL, 32'hFFFF_FFFF);
    rdchk("tsel", fxfer_pkg::OFF_TSEL, 32'h0000_FFFF);
    wr(fxfer_pkg::OFF_TOFF, 32'hFFFF_FFFF);
    rdchk("toff", fxfer_pkg::OFF_TOFF, 32'hFFFF_FFFF);
    wr(fxfer_pkg::OFF_TDESC, 32'hFFFF_FFFF);
    rdchk("tdesc", fxfer_pkg::OFF_TDESC, 32'h0000_0007);
    wr(8'h40, 32'hFFFF_FFFF);
    rdchk("unmapped", 8'h40, 32'h0);
    rdchk("cmd", fxfer_pkg::OFF_CMD, 32'h0);
    end_test("registers");
    // every level, flag and selector field combination
    for (int c = 0; c < 4; c++)
    begin
      cur = c[1:0];
      wr(fxfer_pkg::OFF_CTRL, {26'h0, cur, 4'h0});
      for (int f = 0; f < 2; f++)
        for (int d = 0; d < 4; d++)
          for (int r = 0; r < 4; r++)
          begin
            ok = f ? (d <= c) : (d == c && r <= c);
            ec = f ? 3'h3 : ((d != c) ? 3'h1 : 3'h2);
            sel = {8'hB4, c[1:0], f[0], d[1:0], 1'b1, r[1:0]};
            toff = {16'h8000, sel};
            wr(fxfer_pkg::OFF_TSEL, {16'h0, sel});
            wr(fxfer_pkg::OFF_TOFF, toff);
            wr(fxfer_pkg::OFF_TDESC, {29'h0, f[0], d[1:0]});
            // granted load, no change on fault
            if (ok)
            begin
              exp_cs = {sel[15:2], cur};
              exp_ip = toff;
            end
            cmd(fxfer_pkg::KIND_FAR_DIRECT, !ok, 1'b0);
            if (!ok)
              rdchk("cause", fxfer_pkg::OFF_CAUSE, {29'h0, ec});
          end
    end
    end_test("far direct");
    cur = 2'h0;
    wr(fxfer_pkg::OFF_CTRL, 32'h0);
    wr(fxfer_pkg::OFF_TDESC, 32'h0000_0003);
    wr(fxfer_pkg::OFF_TOFF, 32'h1234_5678);
    wr(fxfer_pkg::OFF_IRQ_STAT, 32'h0000_0007);
    exp_ip = 32'h1234_5678;
    cmd(fxfer_pkg::KIND_NEAR, 1'b0, 1'b0);
    rdchk("near stat", fxfer_pkg::OFF_IRQ_STAT, 32'h0);
    end_test("near");
    // refused kinds in long mode, and codes 5 to 7 in any mode
    for (int m = 1; m >= 0; m--)
    begin
      wr(fxfer_pkg::OFF_CTRL, {31'h0, m[0]});
      for (int k = 2; k < 8; k++)
      begin
        cmd(k[2:0], 1'b0, m[0] || k > 4);
        if (m[0] || k > 4)
          rdchk("unsup cause", fxfer_pkg::OFF_CAUSE, 32'h0000_0004);
      end
    end
    end_test("modes");
    wr(fxfer_pkg::OFF_IRQ_STAT, 32'h0000_0007);
    wr(fxfer_pkg::OFF_IRQ_MASK, 32'h0000_0002);
    cmd(fxfer_pkg::KIND_FAR_DIRECT, 1'b1, 1'b0);
    chk("irq fault", 32'h1, {31'h0, irq_q});
    rdchk("stat fault", fxfer_pkg::OFF_IRQ_STAT, 32'h0000_0002);
    wr(fxfer_pkg::OFF_IRQ_STAT, 32'h0000_0002);
    @(posedge ref_clk);
    #1;
    chk("irq clear", 32'h0, {31'h0, irq_q});
    wr(fxfer_pkg::OFF_TDESC, 32'h0000_0004);
    exp_cs = {sel[15:2], cur};
    cmd(fxfer_pkg::KIND_FAR_DIRECT, 1'b0, 1'b0);
    chk("irq masked", 32'h0, {31'h0, irq_q});
    rdchk("stat grant", fxfer_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    wr(fxfer_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    @(posedge ref_clk);
    #1;
    chk("irq unmasked", 32'h1, {31'h0, irq_q});
    wr(fxfer_pkg::OFF_IRQ_STAT, 32'h0000_0001);
    @(posedge ref_clk);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq_q});
    end_test("interrupt");
    final_report();
  end
endmodule : far_transfer_privilege_check_test
